// ===== core/pjk_pkg.sv
// Purpose: Constants and carrier types for the port J/K/L pin function block
// Assumes: APB register access, 32-bit data, one word per register
// Notes: Offsets are byte addresses; upper bits of each word read as zero
package pjk_pkg;
  localparam int J_PINS = 16;
  localparam int K_PINS = 8;
  localparam int L_PINS = 6;
  localparam int REG_W = 16;
  localparam int ADDR_W = 8;

  localparam logic [ADDR_W-1:0] OFF_J_DIR = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_J_SEL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_J_PU = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_K_DIR = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_K_SEL = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_K_PU = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_L_PU = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_EXT = 8'h1C;

  localparam logic [REG_W-1:0] RST_ZERO = 16'h0000;
  // Writable bit masks; all other bits are reserved and read as zero
  localparam logic [REG_W-1:0] MASK_J = 16'hFFFF;
  localparam logic [REG_W-1:0] MASK_K = 16'h00FF;
  localparam logic [REG_W-1:0] MASK_K_SEL = 16'h003F;
  localparam logic [REG_W-1:0] MASK_L = 16'h003F;
  localparam logic [REG_W-1:0] MASK_EXT = 16'h0100;
  localparam int GIE_BIT = 8;

  // Peripheral bit positions inside the 16-pin port
  localparam int J_SPI_SLAVE_SELECT_3 = 15;
  localparam int J_SPI_SLAVE_SELECT_2 = 14;
  localparam int J_SPI_SLAVE_SELECT_1 = 13;
  localparam int J_SPI_SLAVE_SELECT_0 = 12;
  localparam int J_MISO = 11;
  localparam int J_MOSI = 10;
  localparam int J_SCK = 9;
  localparam int J_RX5 = 8;
  localparam int J_TX5 = 7;
  localparam int J_CK5 = 6;
  localparam int J_RX4 = 5;
  localparam int J_TX4 = 4;
  localparam int J_CK4 = 3;
  localparam int J_IRQ12 = 2;
  localparam int J_IRQ11 = 1;
  localparam int J_IRQ10 = 0;
  // Peripheral bit positions inside the 8-pin port
  localparam int K_RX6 = 5;
  localparam int K_TX6 = 4;
  localparam int K_CK6 = 3;
  localparam int K_IRQ15 = 2;
  localparam int K_IRQ14 = 1;
  localparam int K_IRQ13 = 0;

  localparam int SPI_SEL_W = 4;
  localparam int IRQ_J_W = 3;
  localparam int IRQ_K_W = 3;

  // SPI controller side: output value and enable for each shared line
  typedef struct packed {
    logic [SPI_SEL_W-1:0] sel_o;
    logic [SPI_SEL_W-1:0] sel_oe;
    logic miso_o;
    logic miso_oe;
    logic mosi_o;
    logic mosi_oe;
    logic clk_o;
    logic clk_oe;
  } pjk_spi_out_t;

  typedef struct packed {
    logic sel0_i;
    logic miso_i;
    logic mosi_i;
    logic clk_i;
  } pjk_spi_in_t;

  // One serial channel: transmit and bidirectional clock out
  typedef struct packed {
    logic tx_o;
    logic clk_o;
    logic clk_oe;
  } pjk_ser_out_t;

  typedef struct packed {
    logic rx_i;
    logic clk_i;
  } pjk_ser_in_t;
endpackage : pjk_pkg

// ===== core/pjk_pin_ctrl.sv
// Purpose: Pin function control for the 16-pin, 8-pin and 6-pin ports
// Assumes: APB slave with zero wait states, pins passed through combinationally, not registered on sys_clk
// Notes: Pull-up enables for the 16-pin and 8-pin ports are plain outputs to the pad cells; the 6-pin port's are gated by the stop bit
//
// The register addresses and the APB register port were chosen for this implementation.
module pjk_pin_ctrl #(
  parameter bit STOP_GATED = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic display_module_stop,
  input wire logic [pjk_pkg::J_PINS-1:0] pin_j_in,
  output logic [pjk_pkg::J_PINS-1:0] pin_j_out,
  output logic [pjk_pkg::J_PINS-1:0] pin_j_oe,
  output logic [pjk_pkg::J_PINS-1:0] pin_j_pullup,
  input wire logic [pjk_pkg::K_PINS-1:0] pin_k_in,
  output logic [pjk_pkg::K_PINS-1:0] pin_k_out,
  output logic [pjk_pkg::K_PINS-1:0] pin_k_oe,
  output logic [pjk_pkg::K_PINS-1:0] pin_k_pullup,
  input wire logic [pjk_pkg::L_PINS-1:0] pin_l_in,
  output logic [pjk_pkg::L_PINS-1:0] pin_l_pullup,
  output logic [pjk_pkg::L_PINS-1:0] port_l_in,
  input wire logic [pjk_pkg::J_PINS-1:0] port_j_out_val,
  output logic [pjk_pkg::J_PINS-1:0] port_j_in,
  input wire logic [pjk_pkg::K_PINS-1:0] port_k_out_val,
  output logic [pjk_pkg::K_PINS-1:0] port_k_in,
  input wire pjk_pkg::pjk_spi_out_t spi_out,
  output pjk_pkg::pjk_spi_in_t spi_in,
  input wire pjk_pkg::pjk_ser_out_t ser4_out,
  output pjk_pkg::pjk_ser_in_t ser4_in,
  input wire pjk_pkg::pjk_ser_out_t ser5_out,
  output pjk_pkg::pjk_ser_in_t ser5_in,
  input wire pjk_pkg::pjk_ser_out_t ser6_out,
  output pjk_pkg::pjk_ser_in_t ser6_in,
  output logic [pjk_pkg::IRQ_J_W-1:0] irq_j,
  output logic [pjk_pkg::IRQ_K_W-1:0] irq_k
);

  // Elaboration check: 16-pin and 8-pin port counts fit the 16-bit registers
  if (pjk_pkg::J_PINS > pjk_pkg::REG_W || pjk_pkg::K_PINS > pjk_pkg::REG_W) begin : g_chk
    $error("pin count exceeds register width");
  end

  logic [pjk_pkg::REG_W-1:0] j_dir_q;
  logic [pjk_pkg::REG_W-1:0] j_sel_q;
  logic [pjk_pkg::REG_W-1:0] j_pu_q;
  logic [pjk_pkg::REG_W-1:0] k_dir_q;
  logic [pjk_pkg::REG_W-1:0] k_sel_q;
  logic [pjk_pkg::REG_W-1:0] k_pu_q;
  logic [pjk_pkg::REG_W-1:0] l_pu_q;
  logic [pjk_pkg::REG_W-1:0] ext_q;
  logic [31:0] prdata_q;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [pjk_pkg::REG_W-1:0] wdata16;
  logic [pjk_pkg::REG_W-1:0] rd_mux;
  logic [pjk_pkg::ADDR_W-1:0] addr;
  logic gie;
  logic l_port_mode;
  logic [pjk_pkg::J_PINS-1:0] j_per_o;
  logic [pjk_pkg::J_PINS-1:0] j_per_oe;
  logic [pjk_pkg::K_PINS-1:0] k_per_o;
  logic [pjk_pkg::K_PINS-1:0] k_per_oe;

  assign addr = paddr[pjk_pkg::ADDR_W-1:0];
  assign wdata16 = pwdata[pjk_pkg::REG_W-1:0];
  assign gie = ext_q[pjk_pkg::GIE_BIT];

  // Address decode; upper address bits must be zero for a hit
  always_comb begin
    hit = (paddr[31:pjk_pkg::ADDR_W] == '0) && (addr[1:0] == 2'h0) &&
          (addr <= pjk_pkg::OFF_EXT);
  end

  // Zero wait states; unmapped word answers with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign wr_en = psel && penable && pwrite && hit && pstrb[0] && pstrb[1];
  assign rd_en = psel && penable && !pwrite && hit;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      j_dir_q <= pjk_pkg::RST_ZERO;
    end else if (wr_en && addr == pjk_pkg::OFF_J_DIR) begin
      j_dir_q <= wdata16 & pjk_pkg::MASK_J;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      j_sel_q <= pjk_pkg::RST_ZERO;
    end else if (wr_en && addr == pjk_pkg::OFF_J_SEL) begin
      j_sel_q <= wdata16 & pjk_pkg::MASK_J;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      j_pu_q <= pjk_pkg::RST_ZERO;
    end else if (wr_en && addr == pjk_pkg::OFF_J_PU) begin
      j_pu_q <= wdata16 & pjk_pkg::MASK_J;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      k_dir_q <= pjk_pkg::RST_ZERO;
    end else if (wr_en && addr == pjk_pkg::OFF_K_DIR) begin
      k_dir_q <= wdata16 & pjk_pkg::MASK_K;
    end
  end

  // prohibited bits dropped
  // Bits 7 and 6 have no function, so they never store a one
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      k_sel_q <= pjk_pkg::RST_ZERO;
    end else if (wr_en && addr == pjk_pkg::OFF_K_SEL) begin
      k_sel_q <= wdata16 & pjk_pkg::MASK_K_SEL;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      k_pu_q <= pjk_pkg::RST_ZERO;
    end else if (wr_en && addr == pjk_pkg::OFF_K_PU) begin
      k_pu_q <= wdata16 & pjk_pkg::MASK_K;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      l_pu_q <= pjk_pkg::RST_ZERO;
    end else if (wr_en && addr == pjk_pkg::OFF_L_PU) begin
      l_pu_q <= wdata16 & pjk_pkg::MASK_L;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ext_q <= pjk_pkg::RST_ZERO;
    end else if (wr_en && addr == pjk_pkg::OFF_EXT) begin
      ext_q <= wdata16 & pjk_pkg::MASK_EXT;
    end
  end

  always_comb begin
    unique case (addr)
      pjk_pkg::OFF_J_DIR: rd_mux = j_dir_q;
      pjk_pkg::OFF_J_SEL: rd_mux = j_sel_q;
      pjk_pkg::OFF_J_PU: rd_mux = j_pu_q;
      pjk_pkg::OFF_K_DIR: rd_mux = k_dir_q;
      pjk_pkg::OFF_K_SEL: rd_mux = k_sel_q;
      pjk_pkg::OFF_K_PU: rd_mux = k_pu_q;
      pjk_pkg::OFF_L_PU: rd_mux = l_pu_q;
      pjk_pkg::OFF_EXT: rd_mux = ext_q;
      default: rd_mux = pjk_pkg::RST_ZERO;
    endcase
  end

  // Read data registered in the setup cycle so it is stable in access
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= {16'h0000, rd_mux};
    end
  end
  assign prdata = rd_en ? prdata_q : 32'h0000_0000;

  always_comb begin
    j_per_o = '0;
    j_per_oe = '0;
    j_per_o[pjk_pkg::J_SPI_SLAVE_SELECT_3] = spi_out.sel_o[3];
    j_per_oe[pjk_pkg::J_SPI_SLAVE_SELECT_3] = spi_out.sel_oe[3];
    j_per_o[pjk_pkg::J_SPI_SLAVE_SELECT_2] = spi_out.sel_o[2];
    j_per_oe[pjk_pkg::J_SPI_SLAVE_SELECT_2] = spi_out.sel_oe[2];
    j_per_o[pjk_pkg::J_SPI_SLAVE_SELECT_1] = spi_out.sel_o[1];
    j_per_oe[pjk_pkg::J_SPI_SLAVE_SELECT_1] = spi_out.sel_oe[1];
    j_per_o[pjk_pkg::J_SPI_SLAVE_SELECT_0] = spi_out.sel_o[0];
    j_per_oe[pjk_pkg::J_SPI_SLAVE_SELECT_0] = spi_out.sel_oe[0];
    j_per_o[pjk_pkg::J_MISO] = spi_out.miso_o;
    j_per_oe[pjk_pkg::J_MISO] = spi_out.miso_oe;
    j_per_o[pjk_pkg::J_MOSI] = spi_out.mosi_o;
    j_per_oe[pjk_pkg::J_MOSI] = spi_out.mosi_oe;
    j_per_o[pjk_pkg::J_SCK] = spi_out.clk_o;
    j_per_oe[pjk_pkg::J_SCK] = spi_out.clk_oe;
    j_per_o[pjk_pkg::J_TX5] = ser5_out.tx_o;
    j_per_oe[pjk_pkg::J_TX5] = 1'b1;
    j_per_o[pjk_pkg::J_CK5] = ser5_out.clk_o;
    j_per_oe[pjk_pkg::J_CK5] = ser5_out.clk_oe;
    j_per_o[pjk_pkg::J_TX4] = ser4_out.tx_o;
    j_per_oe[pjk_pkg::J_TX4] = 1'b1;
    j_per_o[pjk_pkg::J_CK4] = ser4_out.clk_o;
    j_per_oe[pjk_pkg::J_CK4] = ser4_out.clk_oe;
  end

  always_comb begin
    k_per_o = '0;
    k_per_oe = '0;
    k_per_o[pjk_pkg::K_TX6] = ser6_out.tx_o;
    k_per_oe[pjk_pkg::K_TX6] = 1'b1;
    k_per_o[pjk_pkg::K_CK6] = ser6_out.clk_o;
    k_per_oe[pjk_pkg::K_CK6] = ser6_out.clk_oe;
  end

  // Per-pin output mux for the 16-pin port
  for (genvar i = 0; i < pjk_pkg::J_PINS; i++) begin : g_j
    assign pin_j_out[i] = j_sel_q[i] ? j_per_o[i] : port_j_out_val[i];
    assign pin_j_oe[i] = j_sel_q[i] ? j_per_oe[i] : j_dir_q[i];
    assign port_j_in[i] = !j_sel_q[i] && !j_dir_q[i] && gie && pin_j_in[i];
    assign pin_j_pullup[i] = j_pu_q[i];
  end

  // Per-pin output mux for the 8-pin port
  for (genvar i = 0; i < pjk_pkg::K_PINS; i++) begin : g_k
    assign pin_k_out[i] = k_sel_q[i] ? k_per_o[i] : port_k_out_val[i];
    assign pin_k_oe[i] = k_sel_q[i] ? k_per_oe[i] : k_dir_q[i];
    assign port_k_in[i] = !k_sel_q[i] && !k_dir_q[i] && gie && pin_k_in[i];
    assign pin_k_pullup[i] = k_pu_q[i];
  end

  // stop-bit gating
  // Ungated variant sets STOP_GATED to zero
  assign l_port_mode = !STOP_GATED || display_module_stop;
  for (genvar i = 0; i < pjk_pkg::L_PINS; i++) begin : g_l
    assign pin_l_pullup[i] = l_pu_q[i] && l_port_mode;
    // Input-only port has no general input gate in this block
    assign port_l_in[i] = l_port_mode && pin_l_in[i];
  end

  // inputs to peripherals
  // Deselected inputs idle low; interrupt inputs idle low too
  assign spi_in.sel0_i = j_sel_q[pjk_pkg::J_SPI_SLAVE_SELECT_0] && pin_j_in[pjk_pkg::J_SPI_SLAVE_SELECT_0];
  assign spi_in.miso_i = j_sel_q[pjk_pkg::J_MISO] && pin_j_in[pjk_pkg::J_MISO];
  assign spi_in.mosi_i = j_sel_q[pjk_pkg::J_MOSI] && pin_j_in[pjk_pkg::J_MOSI];
  assign spi_in.clk_i = j_sel_q[pjk_pkg::J_SCK] && pin_j_in[pjk_pkg::J_SCK];
  assign ser5_in.rx_i = j_sel_q[pjk_pkg::J_RX5] && pin_j_in[pjk_pkg::J_RX5];
  assign ser5_in.clk_i = j_sel_q[pjk_pkg::J_CK5] && pin_j_in[pjk_pkg::J_CK5];
  assign ser4_in.rx_i = j_sel_q[pjk_pkg::J_RX4] && pin_j_in[pjk_pkg::J_RX4];
  assign ser4_in.clk_i = j_sel_q[pjk_pkg::J_CK4] && pin_j_in[pjk_pkg::J_CK4];
  assign ser6_in.rx_i = k_sel_q[pjk_pkg::K_RX6] && pin_k_in[pjk_pkg::K_RX6];
  assign ser6_in.clk_i = k_sel_q[pjk_pkg::K_CK6] && pin_k_in[pjk_pkg::K_CK6];

  assign irq_j = j_sel_q[pjk_pkg::J_IRQ12:pjk_pkg::J_IRQ10] &
                 pin_j_in[pjk_pkg::J_IRQ12:pjk_pkg::J_IRQ10];
  assign irq_k = k_sel_q[pjk_pkg::K_IRQ15:pjk_pkg::K_IRQ13] &
                 pin_k_in[pjk_pkg::K_IRQ15:pjk_pkg::K_IRQ13];

endmodule : pjk_pin_ctrl

// ===== bench/pjk_board_model.sv
// Purpose: Board side of one multiplexed port, resolving each pin level
// Assumes: Chip output wins over the board; board drive is per pin
// Notes: Undriven pins without pull-up toggle each cycle, never hold a value
module pjk_board_model #(
  parameter int W = 16
) (
  input wire logic sys_clk,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] pu_en,
  input wire logic [W-1:0] drv,
  input wire logic [W-1:0] drv_en,
  output logic [W-1:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0] flt_q = '0;

  // Floating lines wander so a stale value cannot pass for a read
  always @(posedge sys_clk) begin
    flt_q <= ~flt_q;
  end

  // chip drive, board drive, pull-up, float
  always_comb begin
    level = (oe & out) | (~oe & drv_en & drv) | (~oe & ~drv_en & (pu_en | flt_q));
  end
endmodule : pjk_board_model

// ===== bench/pjk_pin_ctrl_props.sv
// Purpose: Port-level checks for the pin function block
// Assumes: One clock domain, sees only the top ports
// Notes: Bound into every instance of the block
module pjk_pin_ctrl_props #(
  parameter bit STOP_GATED = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic display_module_stop,
  input wire logic [15:0] pin_j_in,
  input wire logic [15:0] pin_j_oe,
  input wire logic [15:0] port_j_in,
  input wire logic [7:0] pin_k_in,
  input wire logic [7:0] pin_k_oe,
  input wire logic [7:0] port_k_in,
  input wire logic [5:0] pin_l_pullup,
  input wire pjk_pkg::pjk_ser_in_t ser6_in,
  input wire logic [2:0] irq_j,
  input wire logic [2:0] irq_k
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_err; psel && penable && pslverr |-> prdata == 32'h00000000; endproperty
  a_err: assert property (p_err) else $error("refused access returned data");
  property p_jin; port_j_in == (port_j_in & pin_j_in & ~pin_j_oe); endproperty
  a_jin: assert property (p_jin) else $error("port J input passed a driven pin");
  property p_kin; port_k_in == (port_k_in & pin_k_in & ~pin_k_oe); endproperty
  a_kin: assert property (p_kin) else $error("port K input passed a driven pin");
  property p_irqj; irq_j != 3'h0 |-> (irq_j & ~pin_j_in[2:0] | irq_j & pin_j_oe[2:0]) == 3'h0;
  endproperty
  a_irqj: assert property (p_irqj) else $error("interrupt from J not from pin");
  property p_irqk; (irq_k & (~pin_k_in[2:0] | pin_k_oe[2:0])) == 3'h0; endproperty
  a_irqk: assert property (p_irqk) else $error("interrupt from K not from pin");
  property p_rx6; ser6_in.rx_i |-> pin_k_in[5] && !pin_k_oe[5]; endproperty
  a_rx6: assert property (p_rx6) else $error("serial six receive not from pin");
  property p_lpu; STOP_GATED && !display_module_stop |-> pin_l_pullup == 6'h00; endproperty
  a_lpu: assert property (p_lpu) else $error("port L pull-up while gated");
  property p_rst; $fell(rst) |-> pin_j_oe == 16'h0000 && pin_k_oe == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("pin driven right after reset");
endmodule : pjk_pin_ctrl_props

bind pjk_pin_ctrl pjk_pin_ctrl_props #(.STOP_GATED(STOP_GATED)) i_pjk_pin_ctrl_props (
  .sys_clk, .rst, .psel, .penable, .prdata, .pslverr, .display_module_stop,
  .pin_j_in, .pin_j_oe, .port_j_in, .pin_k_in, .pin_k_oe, .port_k_in,
  .pin_l_pullup, .ser6_in, .irq_j, .irq_k
);

// ===== bench/tb_pjk_pin_ctrl.sv
// Purpose: Self-checking bench for the pin function block
// Assumes: Zero-wait APB slave, board models on all three ports
// Notes: Writes set only documented bits; reserved and prohibited bits stay 0
module tb_pjk_pin_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, serr, display_module_stop;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic [3:0] pstrb, st;
  logic [15:0] pin_j_in, pin_j_out, pin_j_oe, pin_j_pullup, port_j_out_val, port_j_in, jdrv, jen;
  logic [7:0] pin_k_in, pin_k_out, pin_k_oe, pin_k_pullup, port_k_out_val, port_k_in, kdrv, ken;
  logic [5:0] pin_l_in, pin_l_pullup, port_l_in;
  logic [2:0] irq_j, irq_k;
  pjk_pkg::pjk_spi_out_t spi_out;
  pjk_pkg::pjk_spi_in_t spi_in;
  pjk_pkg::pjk_ser_out_t ser4_out, ser5_out, ser6_out;
  pjk_pkg::pjk_ser_in_t ser4_in, ser5_in, ser6_in;
  int n_errors, cmp_count;

  pjk_pin_ctrl i_pjk_pin_ctrl (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .display_module_stop, .pin_j_in, .pin_j_out,
    .pin_j_oe, .pin_j_pullup, .pin_k_in, .pin_k_out, .pin_k_oe, .pin_k_pullup, .pin_l_in,
    .pin_l_pullup, .port_l_in, .port_j_out_val, .port_j_in, .port_k_out_val, .port_k_in,
    .spi_out, .spi_in, .ser4_out, .ser4_in, .ser5_out, .ser5_in, .ser6_out, .ser6_in,
    .irq_j, .irq_k);
  pjk_board_model #(.W(16)) i_pjk_board_model_j (.sys_clk, .oe(pin_j_oe), .out(pin_j_out),
    .pu_en(pin_j_pullup), .drv(jdrv), .drv_en(jen), .level(pin_j_in));
  pjk_board_model #(.W(8)) i_pjk_board_model_k (.sys_clk, .oe(pin_k_oe), .out(pin_k_out),
    .pu_en(pin_k_pullup), .drv(kdrv), .drv_en(ken), .level(pin_k_in));
  pjk_board_model #(.W(6)) i_pjk_board_model_l (.sys_clk, .oe(6'h00), .out(6'h00),
    .pu_en(pin_l_pullup), .drv(jdrv[5:0]), .drv_en(jen[5:0]), .level(pin_l_in));

  // Free-running system clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task end_sim;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h000000, a};
    pwdata <= d;
    pstrb <= st;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      end_sim();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(rdat, e);
  endtask : rd

  task automatic t_regs;
    logic [15:0] m [8] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h00FF, 16'h003F, 16'h00FF,
      16'h003F, 16'h0100};
    foreach (m[i]) rd(8'(4 * i), 32'h00000000);
    foreach (m[i]) wr(8'(4 * i), {16'h0000, m[i]});
    foreach (m[i]) rd(8'(4 * i), {16'h0000, m[i]});
    rd(8'h20, 32'h00000000);
    chk({31'h0, serr}, 32'h00000001);
    st = 4'h1;
    wr(8'h00, 32'h00000000);
    st = 4'hF;
    rd(8'h00, 32'h0000FFFF);
    foreach (m[i]) wr(8'(4 * i), 32'h00000000);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_port;
    wr(8'h1C, 32'h00000100);
    wr(8'h00, 32'h000000F0);
    wr(8'h0C, 32'h0000000F);
    port_j_out_val <= 16'hA5A5;
    port_k_out_val <= 8'h5A;
    jdrv <= 16'h3C3C;
    kdrv <= 8'hC3;
    @(negedge sys_clk);
    chk(pin_j_oe, 16'h00F0);
    chk(pin_j_out & pin_j_oe, 16'h00A0);
    chk(port_j_in, 16'h3C0C);
    chk(pin_k_oe, 8'h0F);
    chk(pin_k_out & pin_k_oe, 8'h0A);
    chk(port_k_in, 8'hC0);
    wr(8'h1C, 32'h00000000);
    @(negedge sys_clk);
    chk({port_j_in, port_k_in}, 24'h000000);
    $display("t_port done");
  endtask : t_port

  task automatic t_periph;
    wr(8'h04, 32'h0000FFFF);
    wr(8'h10, 32'h0000003F);
    wr(8'h00, 32'h0000FFFF);
    wr(8'h0C, 32'h000000FF);
    wr(8'h1C, 32'h00000100);
    jdrv <= 16'h0925;
    kdrv <= 8'h25;
    @(negedge sys_clk);
    chk(pin_j_oe, 16'hF6D0);
    chk(pin_j_out & pin_j_oe, 16'h9680);
    chk({spi_in.miso_i, ser5_in.rx_i, ser4_in.rx_i, irq_j}, 6'h3D);
    chk(port_j_in, 16'h0000);
    chk(pin_k_oe, 8'hD8);
    chk(pin_k_out & pin_k_oe, 8'h58);
    chk({ser6_in.rx_i, irq_k}, 4'hD);
    chk(spi_in, 4'hF);
    chk({ser5_in, ser4_in, ser6_in}, 6'h2B);
    wr(8'h04, 32'h00000000);
    wr(8'h10, 32'h00000000);
    wr(8'h00, 32'h00000000);
    wr(8'h0C, 32'h00000000);
    $display("t_periph done");
  endtask : t_periph

  task automatic t_pull;
    jen <= 16'h0000;
    ken <= 8'h00;
    wr(8'h08, 32'h0000FFFF);
    wr(8'h14, 32'h000000FF);
    wr(8'h18, 32'h0000003F);
    @(negedge sys_clk);
    chk(pin_j_pullup, 16'hFFFF);
    chk(port_j_in, 16'hFFFF);
    chk(pin_k_pullup, 8'hFF);
    chk(pin_l_pullup, 6'h00);
    chk(port_l_in, 6'h00);
    @(posedge sys_clk);
    display_module_stop <= 1'b1;
    @(negedge sys_clk);
    chk(pin_l_pullup, 6'h3F);
    chk(port_l_in, 6'h3F);
    wr(8'h08, 32'h00000000);
    @(negedge sys_clk);
    chk(pin_j_pullup, 16'h0000);
    $display("t_pull done");
  endtask : t_pull

  // Main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    st = 4'hF;
    display_module_stop = 1'b0;
    port_j_out_val = 16'h0000;
    port_k_out_val = 8'h00;
    jdrv = 16'h0000;
    kdrv = 8'h00;
    jen = 16'hFFFF;
    ken = 8'hFF;
    spi_out = 14'h27CF; // Selects 9 all enabled, MISO released, rest driven high
    ser4_out = 3'h2;
    ser5_out = 3'h5;
    ser6_out = 3'h7;
    n_errors = 0;
    cmp_count = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_port();
    t_periph();
    t_pull();
    end_sim();
  end
endmodule : tb_pjk_pin_ctrl
